// ==== rtl/tcms_pkg.sv ====
// =============================================================
// Shared constants of the torque command and mode select block.
// =============================================================
package tcms_pkg;

   // =============================================================
   // Timing.
   // =============================================================
   localparam int unsigned CLK_FREQ_MHZ = 25;
   localparam int unsigned CTRL_CYCLE_US = 1000;
   localparam int unsigned CTRL_CYCLE_CYC = CTRL_CYCLE_US * CLK_FREQ_MHZ;
   localparam int unsigned CTRL_CNT_W = 16;

   // =============================================================
   // Register offsets.
   // =============================================================
   localparam logic [15:0] ADDR_MODE = 16'h0102;
   localparam logic [15:0] ADDR_LIMIT_EN = 16'h0104;
   localparam logic [15:0] ADDR_SMOOTH = 16'h010E;
   localparam logic [15:0] ADDR_SPRE1 = 16'h0112;
   localparam logic [15:0] ADDR_SPRE2 = 16'h0114;
   localparam logic [15:0] ADDR_SPRE3 = 16'h0116;
   localparam logic [15:0] ADDR_TPRE1 = 16'h0118;
   localparam logic [15:0] ADDR_TPRE2 = 16'h011A;
   localparam logic [15:0] ADDR_TPRE3 = 16'h011C;
   localparam logic [15:0] ADDR_FULL_SCALE = 16'h0152;
   localparam logic [15:0] ADDR_MAX_SPEED = 16'h016E;
   localparam logic [15:0] ADDR_STATUS = 16'h0180;

   // =============================================================
   // Reset values and ranges.
   // =============================================================
   localparam logic [15:0] RST_SMOOTH = 16'h0000;
   localparam logic [15:0] RST_FULL_SCALE = 16'h0064;
   localparam logic [15:0] RST_MAX_SPEED = 16'h0BB8;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [1:0] RST_LIMIT_EN = 2'h0;
   localparam logic [15:0] SMOOTH_MAX = 16'h03E8;
   localparam logic [15:0] FULL_SCALE_MAX = 16'h03E8;
   localparam logic signed [15:0] TRQ_PRESET_MAX = 16'sh0BB8;
   localparam logic signed [31:0] TRQ_SCALE_DIV = 32'sh000003E8;

   // =============================================================
   // Field positions.
   // =============================================================
   localparam int unsigned LIM_SPD_BIT = 0;
   localparam int unsigned LIM_TRQ_BIT = 1;
   localparam int unsigned PIN_SERVO = 0;
   localparam int unsigned PIN_TSEL0 = 1;
   localparam int unsigned PIN_TSEL1 = 2;
   localparam int unsigned PIN_SSEL0 = 3;
   localparam int unsigned PIN_SSEL1 = 4;
   localparam int unsigned PIN_MSW = 5;
   localparam int unsigned PIN_COUNT = 6;

   // =============================================================
   // Control mode codes.
   // =============================================================
   localparam logic [7:0] MODE_PT = 8'h00;
   localparam logic [7:0] MODE_S = 8'h02;
   localparam logic [7:0] MODE_T = 8'h03;
   localparam logic [7:0] MODE_SZ = 8'h04;
   localparam logic [7:0] MODE_TZ = 8'h05;
   localparam logic [7:0] MODE_PT_S = 8'h06;
   localparam logic [7:0] MODE_PT_T = 8'h07;
   localparam logic [7:0] MODE_S_T = 8'h0A;

   // Active sub-mode of the drive.
   typedef enum logic [1:0] {SUB_POS, SUB_SPD, SUB_TRQ} tcms_sub_e;

endpackage : tcms_pkg

// ==== rtl/tcms_lpf.sv ====
// =============================================================
// First-order low-pass filter with a time constant in control cycles.
// =============================================================
module tcms_lpf (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Update request and settings.
   input wire logic tick,
   input wire logic [15:0] tau_ms,
   input wire logic signed [15:0] x_in,
   // Smoothed value.
   output logic signed [15:0] y_out
);
   import tcms_pkg::*;

   typedef enum logic {LPF_IDLE, LPF_DIV} tcms_lpf_e;

   tcms_lpf_e state_q, state_d;
   logic signed [33:0] acc_q, acc_d;
   logic [32:0] num_q, num_d;
   logic [32:0] quo_q, quo_d;
   logic [16:0] rem_q, rem_d;
   logic [5:0] cnt_q, cnt_d;
   logic neg_q, neg_d;

   // The accumulator keeps sixteen fraction bits so that slow filters still converge.
   always_comb begin
      logic signed [16:0] diff;
      logic [16:0] mag;
      logic [17:0] rem_sh;
      diff = 17'(x_in) - 17'($signed(acc_q[31:16]));
      mag = diff[16] ? 17'(-diff) : 17'(diff);
      rem_sh = {rem_q, num_q[32]};
      state_d = state_q;
      acc_d = acc_q;
      num_d = num_q;
      quo_d = quo_q;
      rem_d = rem_q;
      cnt_d = cnt_q;
      neg_d = neg_q;
      unique case (state_q)
         LPF_IDLE: begin
            if (tick) begin
               if (tau_ms == 16'h0000) begin
                  acc_d = {{2{x_in[15]}}, x_in, 16'h0000};
               end else begin
                  num_d = {mag, 16'h0000};
                  neg_d = diff[16];
                  rem_d = 17'h00000;
                  quo_d = 33'h000000000;
                  cnt_d = 6'h21;
                  state_d = LPF_DIV;
               end
            end
         end
         LPF_DIV: begin
            num_d = {num_q[31:0], 1'b0};
            if (rem_sh >= {2'b00, tau_ms}) begin
               rem_d = 17'(rem_sh - {2'b00, tau_ms});
               quo_d = {quo_q[31:0], 1'b1};
            end else begin
               rem_d = rem_sh[16:0];
               quo_d = {quo_q[31:0], 1'b0};
            end
            cnt_d = cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               // Step by the difference divided by the time constant.
               acc_d = neg_q ? acc_q - 34'(quo_d) : acc_q + 34'(quo_d);
               state_d = LPF_IDLE;
            end
         end
      endcase
   end

   // Filter state registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= LPF_IDLE;
         acc_q <= 34'sh000000000;
         num_q <= 33'h000000000;
         quo_q <= 33'h000000000;
         rem_q <= 17'h00000;
         cnt_q <= 6'h00;
         neg_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         acc_q <= acc_d;
         num_q <= num_d;
         quo_q <= quo_d;
         rem_q <= rem_d;
         cnt_q <= cnt_d;
         neg_q <= neg_d;
      end
   end

   assign y_out = acc_q[31:16];

endmodule // tcms_lpf

// ==== rtl/tcms_top.sv ====
module tcms_top #(
   parameter int unsigned CTRL_CYCLES = tcms_pkg::CTRL_CYCLE_CYC
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port.
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata_q,
   // Digital inputs from the controller.
   input wire logic servo_on_pin,
   input wire logic torque_select_bit0,
   input wire logic torque_select_bit1,
   input wire logic [1:0] speed_select_bits,
   input wire logic mode_switch_pin,
   // Analog references after conversion.
   input wire logic signed [15:0] torque_ref_mv,
   input wire logic signed [15:0] speed_ref,
   // Commands towards the control loops.
   output tcms_pkg::tcms_sub_e submode_q,
   output logic signed [15:0] torque_cmd_q,
   output logic [15:0] torque_limit_q,
   output logic torque_limit_on_q,
   output logic signed [15:0] speed_cmd_q,
   output logic [15:0] speed_limit_q,
   output logic speed_limit_on_q
);
   import tcms_pkg::*;

   // =============================================================
   // Helper functions.
   // =============================================================

   // Picks the analog source for 00 and a preset otherwise.
   function automatic logic signed [15:0] pick_src(input logic [1:0] sel,
         input logic signed [15:0] ana, input logic signed [15:0] p1,
         input logic signed [15:0] p2, input logic signed [15:0] p3);
      logic signed [15:0] r;
      r = ana;
      unique case (sel)
         2'b00: r = ana;
         2'b01: r = p1;
         2'b10: r = p2;
         2'b11: r = p3;
      endcase
      return r;
   endfunction

   // Magnitude of a signed value.
   function automatic logic [15:0] mag16(input logic signed [15:0] v);
      return v[15] ? 16'(-v) : 16'(v);
   endfunction

   // Unsigned upper clamp.
   function automatic logic [15:0] cap16(input logic [15:0] v, input logic [15:0] lim);
      return (v > lim) ? lim : v;
   endfunction

   // =============================================================
   // Input synchronisers.
   // =============================================================
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q;
   logic [PIN_COUNT-1:0] pin_q, pin_d;

   // Off reads as open and on as closed, so a high pin means on.
   assign pin_raw = {mode_switch_pin, speed_select_bits, torque_select_bit1,
                     torque_select_bit0, servo_on_pin};

   // Each pin passes three flops and counts once the last two agree.
   for (genvar gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      assign pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
   end

   // Synchroniser chain registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
      end else if (ce) begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   logic servo_on;
   logic [1:0] tsel;
   logic [1:0] ssel;
   logic msw;

   assign servo_on = pin_q[PIN_SERVO];
   assign tsel = {pin_q[PIN_TSEL1], pin_q[PIN_TSEL0]};
   assign ssel = {pin_q[PIN_SSEL1], pin_q[PIN_SSEL0]};
   assign msw = pin_q[PIN_MSW];

   // =============================================================
   // Control cycle timer.
   // =============================================================
   logic [CTRL_CNT_W-1:0] cyc_q, cyc_d;
   logic tick_q, tick_d;

   // One tick per control cycle paces the smoothing filter.
   always_comb begin
      tick_d = 1'b0;
      cyc_d = cyc_q + 1'b1;
      if (cyc_q == CTRL_CNT_W'(CTRL_CYCLES - 1)) begin
         cyc_d = '0;
         tick_d = 1'b1;
      end
   end

   // Timer registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_q <= '0;
         tick_q <= 1'b0;
      end else if (ce) begin
         cyc_q <= cyc_d;
         tick_q <= tick_d;
      end
   end

   // =============================================================
   // Register file.
   // =============================================================
   logic [15:0] smooth_q, smooth_d;
   logic [15:0] fs_q, fs_d;
   logic [15:0] maxspd_q, maxspd_d;
   logic [7:0] mode_q, mode_d;
   logic [1:0] lim_en_q, lim_en_d;
   logic signed [15:0] tpre_q [3];
   logic signed [15:0] tpre_d [3];
   logic signed [15:0] spre_q [3];
   logic signed [15:0] spre_d [3];
   logic [15:0] rdata_d;
   logic [15:0] status;
   logic signed [15:0] wsat;

   assign status = {8'h00, submode_q, servo_on, tsel, ssel, msw};

   // Smoothing, full-scale, torque preset and mode writes are range-checked, and reads answer one cycle later.
   always_comb begin
      smooth_d = smooth_q;
      fs_d = fs_q;
      maxspd_d = maxspd_q;
      mode_d = mode_q;
      lim_en_d = lim_en_q;
      tpre_d = tpre_q;
      spre_d = spre_q;
      rdata_d = 16'h0000;
      wsat = $signed(reg_wdata);
      if (wsat > TRQ_PRESET_MAX) begin
         wsat = TRQ_PRESET_MAX;
      end else if (wsat < -TRQ_PRESET_MAX) begin
         wsat = -TRQ_PRESET_MAX;
      end
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_SMOOTH: smooth_d = cap16(reg_wdata, SMOOTH_MAX);
            ADDR_FULL_SCALE: fs_d = cap16(reg_wdata, FULL_SCALE_MAX);
            ADDR_MAX_SPEED: maxspd_d = reg_wdata;
            ADDR_LIMIT_EN: lim_en_d = reg_wdata[1:0];
            ADDR_TPRE1: tpre_d[0] = wsat;
            ADDR_TPRE2: tpre_d[1] = wsat;
            ADDR_TPRE3: tpre_d[2] = wsat;
            ADDR_SPRE1: spre_d[0] = $signed(reg_wdata);
            ADDR_SPRE2: spre_d[1] = $signed(reg_wdata);
            ADDR_SPRE3: spre_d[2] = $signed(reg_wdata);
            ADDR_MODE: begin
               if (reg_wdata[7:0] inside {MODE_PT, MODE_S, MODE_T, MODE_SZ, MODE_TZ,
                                          MODE_PT_S, MODE_PT_T, MODE_S_T}) begin
                  mode_d = reg_wdata[7:0];
               end
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_SMOOTH: rdata_d = smooth_q;
            ADDR_FULL_SCALE: rdata_d = fs_q;
            ADDR_MAX_SPEED: rdata_d = maxspd_q;
            ADDR_LIMIT_EN: rdata_d = {14'h0000, lim_en_q};
            ADDR_MODE: rdata_d = {8'h00, mode_q};
            ADDR_TPRE1: rdata_d = tpre_q[0];
            ADDR_TPRE2: rdata_d = tpre_q[1];
            ADDR_TPRE3: rdata_d = tpre_q[2];
            ADDR_SPRE1: rdata_d = spre_q[0];
            ADDR_SPRE2: rdata_d = spre_q[1];
            ADDR_SPRE3: rdata_d = spre_q[2];
            ADDR_STATUS: rdata_d = status;
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // Register file flops.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         smooth_q <= RST_SMOOTH;
         fs_q <= RST_FULL_SCALE;
         maxspd_q <= RST_MAX_SPEED;
         mode_q <= RST_MODE;
         lim_en_q <= RST_LIMIT_EN;
         tpre_q <= '{default: 16'sh0000};
         spre_q <= '{default: 16'sh0000};
         reg_rdata_q <= 16'h0000;
      end else if (ce) begin
         smooth_q <= smooth_d;
         fs_q <= fs_d;
         maxspd_q <= maxspd_d;
         mode_q <= mode_d;
         lim_en_q <= lim_en_d;
         tpre_q <= tpre_d;
         spre_q <= spre_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // =============================================================
   // Command processing.
   // =============================================================
   tcms_sub_e sub_d;
   logic signed [31:0] prod;
   logic signed [15:0] ana_t;
   logic signed [15:0] trq_raw;
   logic signed [15:0] trq_filt;
   logic signed [15:0] trq_cmd_d;
   logic [15:0] trq_lim_d;
   logic trq_lim_on_d;
   logic signed [15:0] spd_cmd_d;
   logic [15:0] spd_lim_d;
   logic spd_lim_on_d;

   // Scales millivolts by the full-scale percent, giving tenths of a percent.
   assign prod = 32'(torque_ref_mv) * $signed({16'h0000, fs_q});
   assign ana_t = 16'(prod / TRQ_SCALE_DIV);

   // Chooses the sub-mode, then the sources, commands and limits.
   always_comb begin
      logic zero_t;
      logic zero_s;
      logic signed [15:0] tl_src;
      logic [15:0] sl_mag;
      tl_src = 16'sh0000;
      sl_mag = 16'h0000;
      zero_t = (mode_q == MODE_TZ);
      zero_s = (mode_q == MODE_SZ);
      unique case (mode_q)
         MODE_PT: sub_d = SUB_POS;
         MODE_S, MODE_SZ: sub_d = SUB_SPD;
         MODE_T, MODE_TZ: sub_d = SUB_TRQ;
         MODE_PT_S: sub_d = msw ? SUB_SPD : SUB_POS;
         MODE_PT_T: sub_d = msw ? SUB_TRQ : SUB_POS;
         MODE_S_T: sub_d = msw ? SUB_TRQ : SUB_SPD;
         default: sub_d = SUB_POS;
      endcase
      trq_raw = 16'sh0000;
      if (servo_on) begin
         if (tsel == 2'b00) begin
            trq_raw = zero_t ? 16'sh0000 : ana_t;
         end else begin
            trq_raw = pick_src(tsel, ana_t, tpre_q[0], tpre_q[1], tpre_q[2]);
         end
      end
      // The smoothed torque reaches the torque command only in torque mode.
      trq_cmd_d = (sub_d == SUB_TRQ) ? trq_filt : 16'sh0000;
      spd_cmd_d = 16'sh0000;
      if (servo_on && sub_d == SUB_SPD) begin
         if (ssel == 2'b00) begin
            spd_cmd_d = zero_s ? 16'sh0000 : speed_ref;
         end else begin
            spd_cmd_d = pick_src(ssel, speed_ref, spre_q[0], spre_q[1], spre_q[2]);
         end
      end
      // Select inputs steer the torque limit only while it is enabled.
      tl_src = lim_en_q[LIM_TRQ_BIT]
               ? pick_src(tsel, ana_t, tpre_q[0], tpre_q[1], tpre_q[2]) : ana_t;
      trq_lim_on_d = servo_on && lim_en_q[LIM_TRQ_BIT] && sub_d != SUB_TRQ;
      trq_lim_d = trq_lim_on_d ? mag16(tl_src) : 16'h0000;
      sl_mag = mag16(pick_src(ssel, speed_ref, spre_q[0], spre_q[1], spre_q[2]));
      spd_lim_on_d = servo_on && lim_en_q[LIM_SPD_BIT] && sub_d == SUB_TRQ;
      spd_lim_d = spd_lim_on_d ? cap16(sl_mag, maxspd_q) : 16'h0000;
   end

   // Torque command smoothing.
   tcms_lpf u_lpf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .tick(tick_q),
      .tau_ms(smooth_q),
      .x_in(trq_raw),
      .y_out(trq_filt)
   );

   // Output registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         submode_q <= SUB_POS;
         torque_cmd_q <= 16'sh0000;
         torque_limit_q <= 16'h0000;
         torque_limit_on_q <= 1'b0;
         speed_cmd_q <= 16'sh0000;
         speed_limit_q <= 16'h0000;
         speed_limit_on_q <= 1'b0;
      end else if (ce) begin
         submode_q <= sub_d;
         torque_cmd_q <= trq_cmd_d;
         torque_limit_q <= trq_lim_d;
         torque_limit_on_q <= trq_lim_on_d;
         speed_cmd_q <= spd_cmd_d;
         speed_limit_q <= spd_lim_d;
         speed_limit_on_q <= spd_lim_on_d;
      end
   end

endmodule // tcms_top

// ==== bench/tcms_ctrl_model.sv ====
// ====================
// Controller model: drives the digital inputs and analog references.
// ====================
module tcms_ctrl_model (
   // Clock.
   input wire logic core_clk,
   // Levels asked for by the bench.
   input wire logic servo_want,
   input wire logic [1:0] tsel_want,
   input wire logic [1:0] ssel_want,
   input wire logic msw_want,
   input wire logic signed [15:0] mv_want,
   input wire logic signed [15:0] sref_want,
   // Lines towards the drive.
   output logic servo_on_pin = 1'b0,
   output logic torque_select_bit0 = 1'b0,
   output logic torque_select_bit1 = 1'b0,
   output logic [1:0] speed_select_bits = 2'h0,
   output logic mode_switch_pin = 1'b0,
   output logic signed [15:0] torque_ref_mv = 16'sh0000,
   output logic signed [15:0] speed_ref = 16'sh0000
);
   timeunit 1ns;
   timeprecision 1ps;
   // Lines change just after an edge; a high level is a closed contact.
   always @(posedge core_clk) begin
      servo_on_pin <= servo_want;
      torque_select_bit0 <= tsel_want[0];
      torque_select_bit1 <= tsel_want[1];
      speed_select_bits <= ssel_want;
      mode_switch_pin <= msw_want;
      torque_ref_mv <= mv_want;
      speed_ref <= sref_want;
   end
endmodule // tcms_ctrl_model

// ==== bench/tcms_top_properties.sv ====
// ====================
// Port checker of the command block.
// ====================
module tcms_top_properties
   import tcms_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Causes.
   input wire logic reg_wr,
   input wire logic servo_on_pin,
   input wire logic mode_switch_pin,
   // Results.
   input wire tcms_pkg::tcms_sub_e submode_q,
   input wire logic signed [15:0] torque_cmd_q,
   input wire logic [15:0] torque_limit_q,
   input wire logic torque_limit_on_q,
   input wire logic signed [15:0] speed_cmd_q,
   input wire logic [15:0] speed_limit_q,
   input wire logic speed_limit_on_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_tcmd_sub;
      torque_cmd_q != 16'sh0000 |-> submode_q == SUB_TRQ;
   endproperty
   a_tcmd_sub: assert property (p_tcmd_sub) else $error("torque command off torque mode");
   property p_scmd_sub;
      speed_cmd_q != 16'sh0000 |-> submode_q == SUB_SPD;
   endproperty
   a_scmd_sub: assert property (p_scmd_sub) else $error("speed command off speed mode");
   property p_tlim_mode;
      torque_limit_on_q |-> submode_q != SUB_TRQ;
   endproperty
   a_tlim_mode: assert property (p_tlim_mode) else $error("torque limit in torque mode");
   property p_slim_mode;
      speed_limit_on_q |-> submode_q == SUB_TRQ;
   endproperty
   a_slim_mode: assert property (p_slim_mode) else $error("speed limit off torque mode");
   property p_tlim_zero;
      !torque_limit_on_q |-> torque_limit_q == 16'h0000;
   endproperty
   a_tlim_zero: assert property (p_tlim_zero) else $error("idle torque limit not zero");
   property p_slim_zero;
      !speed_limit_on_q |-> speed_limit_q == 16'h0000;
   endproperty
   a_slim_zero: assert property (p_slim_zero) else $error("idle speed limit not zero");
   property p_servo_off;
      !servo_on_pin [*7] |-> !torque_limit_on_q && !speed_limit_on_q && speed_cmd_q == 16'sh0000;
   endproperty
   a_servo_off: assert property (p_servo_off) else $error("active output without servo");
   // Sub-mode only moves after a register write or an input change.
   property p_sub_hold;
      (!reg_wr && $stable(mode_switch_pin) && $stable(servo_on_pin)) [*7] |=> $stable(submode_q);
   endproperty
   a_sub_hold: assert property (p_sub_hold) else $error("sub-mode moved without cause");
   c_trq_slim: cover property (submode_q == SUB_TRQ && speed_limit_on_q);
   c_tlim: cover property (torque_limit_on_q && torque_limit_q != 16'h0000);
   c_spd: cover property (submode_q == SUB_SPD && speed_cmd_q != 16'sh0000);
endmodule // tcms_top_properties

bind tcms_top tcms_top_properties u_tcms_top_properties (
   .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .servo_on_pin(servo_on_pin),
   .mode_switch_pin(mode_switch_pin), .submode_q(submode_q), .torque_cmd_q(torque_cmd_q),
   .torque_limit_q(torque_limit_q), .torque_limit_on_q(torque_limit_on_q),
   .speed_cmd_q(speed_cmd_q), .speed_limit_q(speed_limit_q), .speed_limit_on_q(speed_limit_on_q)
);

// ==== bench/tb_top.sv ====
// ====================
// Self-checking bench of the command block.
// ====================
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tcms_pkg::*;
   localparam int CC = 64;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic w_servo = 1'b0;
   logic w_msw = 1'b0;
   logic [1:0] w_tsel = 2'h0;
   logic [1:0] w_ssel = 2'h0;
   logic signed [15:0] w_mv = 16'sh0000;
   logic signed [15:0] w_sref = 16'sh0000;
   logic [15:0] reg_rdata_q, torque_limit_q, speed_limit_q;
   logic servo_on_pin, torque_select_bit0, torque_select_bit1, mode_switch_pin;
   logic torque_limit_on_q, speed_limit_on_q;
   logic [1:0] speed_select_bits;
   logic signed [15:0] torque_ref_mv, speed_ref, torque_cmd_q, speed_cmd_q;
   tcms_sub_e submode_q;
   int miscompares = 0;
   int samples_checked = 0;
   int seed = 75;
   int cyc = 0;
   int fs, mv, sr, ana;
   int tpre[4];
   logic [7:0] dm[3] = '{MODE_PT_S, MODE_PT_T, MODE_S_T};
   tcms_sub_e sub_on[3] = '{SUB_SPD, SUB_TRQ, SUB_TRQ};
   tcms_sub_e sub_off[3] = '{SUB_POS, SUB_POS, SUB_SPD};

   tcms_ctrl_model u_tcms_ctrl_model (.core_clk(core_clk), .servo_want(w_servo),
      .tsel_want(w_tsel), .ssel_want(w_ssel), .msw_want(w_msw), .mv_want(w_mv),
      .sref_want(w_sref), .servo_on_pin(servo_on_pin), .torque_select_bit0(torque_select_bit0),
      .torque_select_bit1(torque_select_bit1), .speed_select_bits(speed_select_bits),
      .mode_switch_pin(mode_switch_pin), .torque_ref_mv(torque_ref_mv), .speed_ref(speed_ref));

   tcms_top #(.CTRL_CYCLES(CC)) u_tcms_top (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .servo_on_pin(servo_on_pin),
      .torque_select_bit0(torque_select_bit0), .torque_select_bit1(torque_select_bit1),
      .speed_select_bits(speed_select_bits), .mode_switch_pin(mode_switch_pin),
      .torque_ref_mv(torque_ref_mv), .speed_ref(speed_ref), .submode_q(submode_q),
      .torque_cmd_q(torque_cmd_q), .torque_limit_q(torque_limit_q),
      .torque_limit_on_q(torque_limit_on_q), .speed_cmd_q(speed_cmd_q),
      .speed_limit_q(speed_limit_q), .speed_limit_on_q(speed_limit_on_q));

   // Free-running core clock.
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // Model arithmetic.
   function automatic int cl(int v, int m);
      return v > m ? m : (v < -m ? -m : v);
   endfunction
   function automatic int ab(int v);
      return v < 0 ? -v : v;
   endfunction

   // Compare one value and count it.
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One write cycle, then one idle cycle so strobes never merge.
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   // One read cycle; data stand only in the following cycle.
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata_q, exp);
      @(posedge core_clk);
   endtask

   // Wait out one control cycle plus the input path.
   task automatic settle();
      repeat (CC + 12) @(posedge core_clk);
      #1;
   endtask

   // Print the counts and the verdict, then stop.
   task automatic conclude();
      $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         conclude();
      end
   end

   // Main sequence.
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(ADDR_SMOOTH, RST_SMOOTH);
      rd(ADDR_FULL_SCALE, RST_FULL_SCALE);
      rd(16'h0200, 16'h0000);
      wr(ADDR_SMOOTH, 16'h07D0);
      rd(ADDR_SMOOTH, SMOOTH_MAX);
      wr(ADDR_SMOOTH, 16'h0000);
      wr(ADDR_MODE, {8'h00, MODE_T});
      sr = $random(seed) % 2000;
      w_sref <= 16'(sr);
      w_servo <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         fs = ($random(seed) & 32'h3FF) % 1001;
         mv = $random(seed) % 10001;
         ana = mv * fs / 1000;
         wr(ADDR_FULL_SCALE, 16'(fs));
         w_mv <= 16'(mv);
         settle();
         check(torque_cmd_q, 16'(ana));
         check({15'h0, torque_limit_on_q}, 16'h0000);
      end
      for (int s = 1; s < 4; s++) begin
         tpre[s] = $random(seed) % 4000;
         wr(ADDR_TPRE1 + 16'(2 * (s - 1)), 16'(tpre[s]));
      end
      for (int s = 3; s >= 0; s--) begin
         w_tsel <= 2'(s);
         settle();
         check(torque_cmd_q, 16'(s == 0 ? ana : cl(tpre[s], 3000)));
      end
      w_servo <= 1'b0;
      settle();
      check(torque_cmd_q, 16'h0000);
      w_servo <= 1'b1;
      wr(ADDR_MODE, {8'h00, MODE_TZ});
      settle();
      check(torque_cmd_q, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_MODE, {8'h00, dm[i]});
         for (int p = 0; p < 2; p++) begin
            w_msw <= p[0];
            settle();
            check({14'h0, submode_q}, {14'h0, p == 1 ? sub_on[i] : sub_off[i]});
         end
      end
      check(torque_cmd_q, 16'(ana));
      w_msw <= 1'b0;
      settle();
      check(speed_cmd_q, 16'(sr));
      w_ssel <= 2'h1;
      wr(ADDR_SPRE1, 16'h01F4);
      settle();
      check(speed_cmd_q, 16'h01F4);
      w_ssel <= 2'h0;
      w_tsel <= 2'h0;
      wr(ADDR_MODE, {8'h00, MODE_S});
      wr(ADDR_LIMIT_EN, 16'h0002);
      settle();
      check({15'h0, torque_limit_on_q}, 16'h0001);
      check(torque_limit_q, 16'(ab(ana)));
      w_tsel <= 2'h2;
      settle();
      check(torque_limit_q, 16'(ab(cl(tpre[2], 3000))));
      wr(ADDR_LIMIT_EN, 16'h0000);
      settle();
      check({15'h0, torque_limit_on_q}, 16'h0000);
      wr(ADDR_MODE, {8'h00, MODE_T});
      wr(ADDR_LIMIT_EN, 16'h0003);
      settle();
      check({15'h0, speed_limit_on_q}, 16'h0001);
      check(speed_limit_q, 16'(cl(ab(sr), 3000)));
      check({15'h0, torque_limit_on_q}, 16'h0000);
      w_tsel <= 2'h0;
      w_mv <= 16'sh0000;
      settle();
      wr(ADDR_TPRE1, 16'h03E8);
      wr(ADDR_SMOOTH, 16'h0004);
      w_tsel <= 2'h1;
      repeat (CC + 40) @(posedge core_clk);
      #1 check({15'h0, torque_cmd_q > 0 && torque_cmd_q < 1000}, 16'h0001);
      repeat (60 * CC) @(posedge core_clk);
      #1 check({15'h0, torque_cmd_q >= 999 && torque_cmd_q <= 1000}, 16'h0001);
      conclude();
   end
endmodule // tb_top
